// File: core/adcsq_pkg.sv
// package of register map, field positions and timing for the adc sequencer
package adcsq_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SEL_OFFSET = 8'h04;
    localparam logic [7:0] STAT_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0c;
    localparam logic [7:0] TIMING_OFFSET = 8'h10;
    // control register fields
    localparam int DONE_BIT = 0;
    localparam int SAMPLE_ENABLE_BIT = 1;
    localparam int AUTO_BIT = 2;
    localparam int STOP_BIT = 4;
    localparam int TRIG_LSB = 5;
    localparam int TRIG_W = 3;
    localparam int ON_BIT = 15;
    // input select fields
    localparam int POSA_LSB = 16;
    localparam int NEGA_BIT = 23;
    localparam int POSB_LSB = 24;
    localparam int NEGB_BIT = 31;
    localparam logic [31:0] SEL_WMASK = 32'h8f8f_0000;
    // status/mask bits
    localparam int EV_DONE = 0;
    localparam int EV_STOP = 1;
    localparam int EV_W = 2;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [7:0] SAMPLE_RESET = 8'h04;
    localparam logic [7:0] CONVERT_RESET = 8'h0c;
    // analog mux codes
    localparam logic [3:0] CODE_LAST_AN = 4'hc;
    localparam logic [3:0] CODE_TEMP = 4'hd;
    localparam logic [3:0] CODE_IREF = 4'he;
    localparam logic [3:0] CODE_OPEN = 4'hf;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // sequencer states
    typedef enum logic [1:0] {
        ADCSQ_IDLE = 2'b00,
        ADCSQ_SAMPLE = 2'b01,
        ADCSQ_CONVERT = 2'b10
    } adcsq_state_t;
endpackage

// File: core/adcsq_mux_decode.sv
// input multiplexer decode for one sample setting
`timescale 1ns/1ps
module adcsq_mux_decode #(
    parameter int NUM_AN = 13
) (
    // select fields
    input wire logic [3:0] i_pos_sel,
    input wire logic i_neg_sel,
    // one-hot routing
    output logic [NUM_AN-1:0] o_pos_an,
    output logic o_pos_temp,
    output logic o_pos_iref,
    output logic o_neg_an1,
    output logic o_neg_low_voltage_reference
);
    genvar g;
    generate
        for (g = 0; g < NUM_AN; g++)
        begin : g_an
            // codes 0..12 route the analog inputs; see RULE_11
            assign o_pos_an[g] = (i_pos_sel == 4'(g));
        end
    endgenerate
    // code 15 leaves every positive output open; see RULE_11
    assign o_pos_temp = (i_pos_sel == adcsq_pkg::CODE_TEMP);
    assign o_pos_iref = (i_pos_sel == adcsq_pkg::CODE_IREF);
    assign o_neg_an1 = i_neg_sel; // see RULE_13
    assign o_neg_low_voltage_reference = !i_neg_sel; // see RULE_13
endmodule // adcsq_mux_decode

// File: core/adcsq_top.sv
// adc sample and conversion sequencer with axi4-lite registers
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - with stop-on-irq set, the first completion clears auto-sample.
// RULE_02 - with stop-on-irq clear, conversions go on and overwrite results.
// RULE_03 - with auto-sample set, sampling restarts right after completion.
// RULE_04 - with auto-sample clear, only a software write of 1 starts sampling.
// RULE_05 - sample-enable reads 1 while sampling and 0 while holding.
// RULE_06 - with trigger source 000, writing 0 to sample-enable starts convert.
// RULE_07 - with a nonzero trigger source, hardware ends sampling itself.
// RULE_08 - the done flag sets when a conversion finishes.
// RULE_09 - software clears done by writing 0 without disturbing a conversion.
// RULE_10 - the done flag clears when a new conversion begins.
// RULE_11 - positive select A codes 0-12 pick inputs, 13 temp, 14 iref, 15 open.
// RULE_12 - positive select B in bits 27:24 decodes the same during sample B.
// RULE_13 - negative select A picks input one when 1, low reference when 0.
// RULE_14 - negative select B in bit 31 picks input one or the low reference.
// RULE_15 - unimplemented input select bits ignore writes and read zero.
// RULE_16 - software should avoid access just after clearing the on bit.
// RULE_17 - the interrupt request rises with the done flag in the same cycle.
module adcsq_top #(
    parameter int NUM_AN = 13
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // axi4-lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // converter triggers from other logic and the analog core
    input wire logic i_ext_trigger,
    input wire logic i_conv_finished,
    // analog control
    output logic o_sampling,
    output logic o_convert_start,
    output logic [NUM_AN-1:0] o_pos_an,
    output logic o_pos_temp,
    output logic o_pos_iref,
    output logic o_neg_an1,
    output logic o_neg_low_voltage_reference,
    // interrupt
    output logic o_irq
);
    logic [31:0] ctrl_reg;
    logic [31:0] sel_reg;
    logic [7:0] sample_enable_time_reg;
    logic [7:0] conv_time_reg;
    logic [adcsq_pkg::EV_W-1:0] stat_reg;
    logic [adcsq_pkg::EV_W-1:0] mask_reg;
    adcsq_pkg::adcsq_state_t state_reg;
    logic [7:0] cnt_reg;
    logic use_b_reg;
    logic trig_s1_reg;
    logic trig_s2_reg;
    logic fin_s1_reg;
    logic fin_s2_reg;
    logic fin_d_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] wmask;
    logic [31:0] ctrl_wr;
    logic wr_ctrl;
    logic done_evt;
    logic conv_begin;
    logic hw_end;
    logic sw_start;
    logic sw_end;
    logic [2:0] trig_src;
    logic [NUM_AN-1:0] pos_an_a;
    logic [NUM_AN-1:0] pos_an_b;
    logic pos_temp_a;
    logic pos_temp_b;
    logic pos_iref_a;
    logic pos_iref_b;
    logic neg_an1_a;
    logic neg_an1_b;
    logic nva;
    logic nvb;

    // external levels from pins pass two flops
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            fin_s1_reg <= 1'b0;
            fin_s2_reg <= 1'b0;
            fin_d_reg <= 1'b0;
        end
        else
        begin
            trig_s1_reg <= i_ext_trigger;
            trig_s2_reg <= trig_s1_reg;
            fin_s1_reg <= i_conv_finished;
            fin_s2_reg <= fin_s1_reg;
            fin_d_reg <= fin_s2_reg;
        end
    end

    // write channel capture; address and data may arrive in either order
    assign wr_fire = aw_got_reg && w_got_reg && !o_bvalid;
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= adcsq_pkg::RESP_OKAY;
        end
        else
        begin
            o_awready <= !aw_got_reg && !o_awready && !o_bvalid;
            o_wready <= !w_got_reg && !o_wready && !o_bvalid;
            if (i_awvalid && o_awready)
            begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_got_reg <= 1'b1;
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                o_bvalid <= 1'b1;
                if (awaddr_reg > adcsq_pkg::TIMING_OFFSET
                    || awaddr_reg[1:0] != 2'b00)
                    o_bresp <= adcsq_pkg::RESP_SLVERR;
                else
                    o_bresp <= adcsq_pkg::RESP_OKAY;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{wstrb_reg[b]}};
    end

    assign wr_ctrl = wr_fire && awaddr_reg == adcsq_pkg::CTRL_OFFSET;
    assign ctrl_wr = (ctrl_reg & ~wmask) | (wdata_reg & wmask);
    assign trig_src = ctrl_reg[adcsq_pkg::TRIG_LSB +: adcsq_pkg::TRIG_W];
    assign done_evt = state_reg == adcsq_pkg::ADCSQ_CONVERT
        && fin_s2_reg && !fin_d_reg;
    // software starts only when auto-sample is clear; see RULE_04
    assign sw_start = wr_ctrl && ctrl_wr[adcsq_pkg::SAMPLE_ENABLE_BIT]
        && !ctrl_reg[adcsq_pkg::AUTO_BIT]
        && state_reg == adcsq_pkg::ADCSQ_IDLE;
    // manual end only with trigger source 000; see RULE_06
    assign sw_end = wr_ctrl && !ctrl_wr[adcsq_pkg::SAMPLE_ENABLE_BIT]
        && trig_src == 3'b000 && state_reg == adcsq_pkg::ADCSQ_SAMPLE;
    // hardware end: external trigger or internal counter; see RULE_07
    assign hw_end = state_reg == adcsq_pkg::ADCSQ_SAMPLE && trig_src != 3'b000
        && ((trig_src == 3'b001) ? trig_s2_reg : (cnt_reg == 8'h00));
    assign conv_begin = sw_end || hw_end;

    // sequencer; each finished conversion toggles use_b_reg, so sample b is used on alternate passes
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_reg <= adcsq_pkg::ADCSQ_IDLE;
            cnt_reg <= 8'h00;
            use_b_reg <= 1'b0;
        end
        else if (!ctrl_reg[adcsq_pkg::ON_BIT])
        begin
            state_reg <= adcsq_pkg::ADCSQ_IDLE;
            use_b_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                adcsq_pkg::ADCSQ_IDLE:
                begin
                    if (sw_start || ctrl_reg[adcsq_pkg::AUTO_BIT])
                    begin
                        state_reg <= adcsq_pkg::ADCSQ_SAMPLE;
                        cnt_reg <= sample_enable_time_reg;
                    end
                end
                adcsq_pkg::ADCSQ_SAMPLE:
                begin
                    if (cnt_reg != 8'h00)
                        cnt_reg <= cnt_reg - 8'h01;
                    if (conv_begin)
                        state_reg <= adcsq_pkg::ADCSQ_CONVERT;
                end
                adcsq_pkg::ADCSQ_CONVERT:
                begin
                    if (done_evt)
                    begin
                        use_b_reg <= !use_b_reg;
                        // restart at once in auto mode with stop-on-irq clear; see RULE_03
                        if (ctrl_reg[adcsq_pkg::AUTO_BIT]
                            && !ctrl_reg[adcsq_pkg::STOP_BIT])
                        begin
                            state_reg <= adcsq_pkg::ADCSQ_SAMPLE;
                            cnt_reg <= sample_enable_time_reg;
                        end
                        else
                            state_reg <= adcsq_pkg::ADCSQ_IDLE;
                    end
                end
                default:
                    state_reg <= adcsq_pkg::ADCSQ_IDLE;
            endcase
        end
    end

    // control register; hardware events win over software writes
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ctrl_reg <= adcsq_pkg::CTRL_RESET;
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_reg[adcsq_pkg::ON_BIT] <= ctrl_wr[adcsq_pkg::ON_BIT];
                ctrl_reg[adcsq_pkg::STOP_BIT] <= ctrl_wr[adcsq_pkg::STOP_BIT];
                ctrl_reg[adcsq_pkg::AUTO_BIT] <= ctrl_wr[adcsq_pkg::AUTO_BIT];
                ctrl_reg[adcsq_pkg::TRIG_LSB +: adcsq_pkg::TRIG_W] <=
                    ctrl_wr[adcsq_pkg::TRIG_LSB +: adcsq_pkg::TRIG_W];
                // a written 1 is ignored, a 0 clears; see RULE_09
                if (!ctrl_wr[adcsq_pkg::DONE_BIT])
                    ctrl_reg[adcsq_pkg::DONE_BIT] <= 1'b0;
            end
            // sample-enable mirrors the phase; see RULE_05
            ctrl_reg[adcsq_pkg::SAMPLE_ENABLE_BIT] <=
                (state_reg == adcsq_pkg::ADCSQ_SAMPLE && !conv_begin)
                || (state_reg == adcsq_pkg::ADCSQ_IDLE && ctrl_reg[adcsq_pkg::ON_BIT]
                    && (sw_start || ctrl_reg[adcsq_pkg::AUTO_BIT]))
                || (done_evt && ctrl_reg[adcsq_pkg::AUTO_BIT]
                    && !ctrl_reg[adcsq_pkg::STOP_BIT]); // see RULE_03
            if (conv_begin)
                ctrl_reg[adcsq_pkg::DONE_BIT] <= 1'b0; // see RULE_10
            if (done_evt)
            begin
                ctrl_reg[adcsq_pkg::DONE_BIT] <= 1'b1; // see RULE_08
                if (ctrl_reg[adcsq_pkg::STOP_BIT])
                    ctrl_reg[adcsq_pkg::AUTO_BIT] <= 1'b0; // see RULE_01
            end
        end
    end

    // input select and timing registers
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sel_reg <= adcsq_pkg::SEL_RESET;
            sample_enable_time_reg <= adcsq_pkg::SAMPLE_RESET;
            conv_time_reg <= adcsq_pkg::CONVERT_RESET;
        end
        else if (wr_fire && awaddr_reg == adcsq_pkg::SEL_OFFSET)
            // only implemented bits take a write; see RULE_15
            sel_reg <= ((sel_reg & ~wmask) | (wdata_reg & wmask))
                & adcsq_pkg::SEL_WMASK;
        else if (wr_fire && awaddr_reg == adcsq_pkg::TIMING_OFFSET)
        begin
            if (wstrb_reg[0])
                sample_enable_time_reg <= wdata_reg[7:0];
            if (wstrb_reg[1])
                conv_time_reg <= wdata_reg[15:8];
        end
    end

    // read channel; reading status clears it, new events win
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= adcsq_pkg::RESP_OKAY;
        end
        else
        begin
            o_arready <= !o_arready && !o_rvalid;
            if (rd_fire)
            begin
                o_rvalid <= 1'b1;
                o_rresp <= adcsq_pkg::RESP_OKAY;
                if (i_araddr == adcsq_pkg::CTRL_OFFSET)
                    o_rdata <= ctrl_reg;
                else if (i_araddr == adcsq_pkg::SEL_OFFSET)
                    o_rdata <= sel_reg; // see RULE_15
                else if (i_araddr == adcsq_pkg::STAT_OFFSET)
                    o_rdata <= {30'h0, stat_reg};
                else if (i_araddr == adcsq_pkg::MASK_OFFSET)
                    o_rdata <= {30'h0, mask_reg};
                else if (i_araddr == adcsq_pkg::TIMING_OFFSET)
                    o_rdata <= {16'h0, conv_time_reg, sample_enable_time_reg};
                else
                begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= adcsq_pkg::RESP_SLVERR;
                end
            end
            else if (o_rvalid && i_rready)
                o_rvalid <= 1'b0;
        end
    end
    assign rd_fire = i_arvalid && o_arready;

    // sticky events; irq rises with the done flag; see RULE_17
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            stat_reg <= '0;
            mask_reg <= '0;
            o_irq <= 1'b0;
        end
        else
        begin
            if (rd_fire && i_araddr == adcsq_pkg::STAT_OFFSET)
                stat_reg <= '0;
            if (done_evt)
                stat_reg[adcsq_pkg::EV_DONE] <= 1'b1;
            if (done_evt && ctrl_reg[adcsq_pkg::STOP_BIT])
                stat_reg[adcsq_pkg::EV_STOP] <= 1'b1;
            if (wr_fire && awaddr_reg == adcsq_pkg::MASK_OFFSET && wstrb_reg[0])
                mask_reg <= wdata_reg[adcsq_pkg::EV_W-1:0];
            o_irq <= |(stat_reg & mask_reg)
                || (done_evt && mask_reg[adcsq_pkg::EV_DONE]);
        end
    end

    // analog routing; b decodes like a; see RULE_12 and RULE_14
    adcsq_mux_decode #(.NUM_AN(NUM_AN)) u_dec_a (
        .i_pos_sel(sel_reg[adcsq_pkg::POSA_LSB +: 4]),
        .i_neg_sel(sel_reg[adcsq_pkg::NEGA_BIT]),
        .o_pos_an(pos_an_a),
        .o_pos_temp(pos_temp_a),
        .o_pos_iref(pos_iref_a),
        .o_neg_an1(neg_an1_a),
        .o_neg_low_voltage_reference(nva)
    );
    adcsq_mux_decode #(.NUM_AN(NUM_AN)) u_dec_b (
        .i_pos_sel(sel_reg[adcsq_pkg::POSB_LSB +: 4]),
        .i_neg_sel(sel_reg[adcsq_pkg::NEGB_BIT]),
        .o_pos_an(pos_an_b),
        .o_pos_temp(pos_temp_b),
        .o_pos_iref(pos_iref_b),
        .o_neg_an1(neg_an1_b),
        .o_neg_low_voltage_reference(nvb)
    );

    // analog outputs registered
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_sampling <= 1'b0;
            o_convert_start <= 1'b0;
            o_pos_an <= '0;
            o_pos_temp <= 1'b0;
            o_pos_iref <= 1'b0;
            o_neg_an1 <= 1'b0;
            o_neg_low_voltage_reference <= 1'b1;
        end
        else
        begin
            o_sampling <= ctrl_reg[adcsq_pkg::SAMPLE_ENABLE_BIT];
            o_convert_start <= conv_begin;
            o_pos_an <= use_b_reg ? pos_an_b : pos_an_a;
            o_pos_temp <= use_b_reg ? pos_temp_b : pos_temp_a;
            o_pos_iref <= use_b_reg ? pos_iref_b : pos_iref_a;
            o_neg_an1 <= use_b_reg ? neg_an1_b : neg_an1_a;
            o_neg_low_voltage_reference <= use_b_reg ? nvb : nva;
        end
    end

    sequence s_done;
        done_evt;
    endsequence
    property p_stop_auto;
        @(posedge i_clk) disable iff (!i_resetn)
        s_done and ctrl_reg[adcsq_pkg::STOP_BIT]
            |=> !ctrl_reg[adcsq_pkg::AUTO_BIT];
    endproperty
    a_stop_auto: assert property (p_stop_auto) // see RULE_01
        else $error("auto-sample not cleared on first done");
    property p_keep_going;
        @(posedge i_clk) disable iff (!i_resetn)
        s_done and ctrl_reg[adcsq_pkg::AUTO_BIT]
            and !ctrl_reg[adcsq_pkg::STOP_BIT] and ctrl_reg[adcsq_pkg::ON_BIT]
            |=> state_reg == adcsq_pkg::ADCSQ_SAMPLE;
    endproperty
    a_keep_going: assert property (p_keep_going) // see RULE_02
        else $error("conversions did not continue");
    property p_auto_sample_enable;
        @(posedge i_clk) disable iff (!i_resetn)
        s_done and ctrl_reg[adcsq_pkg::AUTO_BIT]
            and !ctrl_reg[adcsq_pkg::STOP_BIT]
            |=> ctrl_reg[adcsq_pkg::SAMPLE_ENABLE_BIT];
    endproperty
    a_auto_sample_enable: assert property (p_auto_sample_enable) // see RULE_03
        else $error("sample-enable not set in auto mode");
    property p_no_self_start;
        @(posedge i_clk) disable iff (!i_resetn)
        state_reg == adcsq_pkg::ADCSQ_IDLE && !ctrl_reg[adcsq_pkg::AUTO_BIT]
            && !sw_start |=> state_reg == adcsq_pkg::ADCSQ_IDLE;
    endproperty
    a_no_self_start: assert property (p_no_self_start) // see RULE_04
        else $error("sampling started without software");
    property p_sample_enable_bit;
        @(posedge i_clk) disable iff (!i_resetn)
        state_reg == adcsq_pkg::ADCSQ_CONVERT
            |-> !ctrl_reg[adcsq_pkg::SAMPLE_ENABLE_BIT];
    endproperty
    a_sample_enable_bit: assert property (p_sample_enable_bit) // see RULE_05
        else $error("sample-enable high while holding");
    property p_sw_end;
        @(posedge i_clk) disable iff (!i_resetn)
        sw_end |=> state_reg == adcsq_pkg::ADCSQ_CONVERT && o_convert_start;
    endproperty
    a_sw_end: assert property (p_sw_end) // see RULE_06
        else $error("software end did not start conversion");
    property p_hw_end;
        @(posedge i_clk) disable iff (!i_resetn)
        hw_end |=> !ctrl_reg[adcsq_pkg::SAMPLE_ENABLE_BIT]
            && state_reg == adcsq_pkg::ADCSQ_CONVERT;
    endproperty
    a_hw_end: assert property (p_hw_end) // see RULE_07
        else $error("hardware end of sampling failed");
    property p_done_set;
        @(posedge i_clk) disable iff (!i_resetn)
        s_done |=> ctrl_reg[adcsq_pkg::DONE_BIT];
    endproperty
    a_done_set: assert property (p_done_set) // see RULE_08
        else $error("done flag not set");
    property p_irq_with_done;
        @(posedge i_clk) disable iff (!i_resetn)
        s_done and mask_reg[adcsq_pkg::EV_DONE] |=> o_irq;
    endproperty
    a_irq_with_done: assert property (p_irq_with_done) // see RULE_17
        else $error("irq not raised with done");
    property p_done_clr;
        @(posedge i_clk) disable iff (!i_resetn)
        conv_begin |=> !ctrl_reg[adcsq_pkg::DONE_BIT];
    endproperty
    a_done_clr: assert property (p_done_clr) // see RULE_10
        else $error("done flag not cleared at conversion start");
    property p_sel_zero;
        @(posedge i_clk) disable iff (!i_resetn)
        (sel_reg & ~adcsq_pkg::SEL_WMASK) == 32'h0000_0000;
    endproperty
    a_sel_zero: assert property (p_sel_zero) // see RULE_15
        else $error("unimplemented select bit set");
endmodule // adcsq_top

// File: verif/adcsq_analog_model.sv
// analog core model: ends a conversion a fixed time after start
`timescale 1ns/1ps
module adcsq_analog_model #(
    parameter int CONV_CYC = 6
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // handshake with the sequencer
    input wire logic i_start,
    output logic o_finished
);
    int cnt;
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn) cnt <= 0;
        else if (i_start) cnt <= CONV_CYC;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // two cycles high so the two-flop sync cannot miss it
    assign o_finished = (cnt > 0) && (cnt < 3);
endmodule // adcsq_analog_model

// File: verif/tb.sv
// testbench for the adc sequencer
`timescale 1ns/1ps
module tb;
    logic i_clk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0;
    logic i_bready = 0, i_arvalid = 0, i_rready = 0, i_ext_trigger = 0;
    logic [7:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, o_rdata;
    logic [3:0] i_wstrb = 4'hf;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic o_sampling, o_convert_start, o_pos_temp, o_pos_iref;
    logic o_neg_an1, o_neg_low_voltage_reference, i_conv_finished;
    logic [1:0] o_bresp, o_rresp, rsp;
    logic [12:0] o_pos_an;
    int mismatches = 0, n_tests = 0;
    always #2 i_clk = ~i_clk;
    adcsq_top dut (.i_clk, .i_resetn, .i_awvalid, .o_awready, .i_awaddr,
        .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
        .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
        .o_rdata, .o_rresp, .i_ext_trigger, .i_conv_finished, .o_sampling,
        .o_convert_start, .o_pos_an, .o_pos_temp, .o_pos_iref, .o_neg_an1,
        .o_neg_low_voltage_reference, .o_irq);
    adcsq_analog_model model (.i_clk, .i_resetn, .i_start(o_convert_start),
        .o_finished(i_conv_finished));
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, act);
        n_tests++;
        if (act !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask
    // every wait is bounded here
    task tick(inout int n);
        @(posedge i_clk);
        n++;
        if (n > 300)
        begin
            mismatches++;
            end_of_test;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw, w;
        n = 0;
        aw = 0;
        w = 0;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        while (!(aw && w))
        begin
            tick(n);
            aw = aw | o_awready;
            w = w | o_wready;
            if (aw) i_awvalid <= 0;
            if (w) i_wvalid <= 0;
        end
        while (o_bvalid !== 1'b1) tick(n);
        rsp = o_bresp;
        i_bready <= 0;
        @(posedge i_clk); // idle edge between accesses
    endtask
    task rc(input string what, input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        do tick(n); while (o_arready !== 1'b1);
        i_arvalid <= 0;
        while (o_rvalid !== 1'b1) tick(n);
        rsp = o_rresp;
        chk(what, e, o_rdata);
        i_rready <= 0;
        @(posedge i_clk);
    endtask
    task wirq;
        int n;
        n = 0;
        while (o_irq !== 1'b1) tick(n);
    endtask
    function automatic logic [31:0] route;
        return 32'({o_pos_an, o_pos_temp, o_pos_iref, o_neg_an1, o_neg_low_voltage_reference});
    endfunction
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_resetn <= 1;
        @(posedge i_clk);
        rc("ctrl", 8'h00, 32'h0);
        rc("sel", 8'h04, 32'h0);
        rc("bad", 8'h14, 32'h0);
        chk("rresp", 32'h2, 32'(rsp));
        wr(8'h14, 32'h1);
        chk("bresp", 32'h2, 32'(rsp));
        wr(8'h04, 32'hffff_ffff);
        chk("bresp", 32'h0, 32'(rsp));
        rc("sel", 8'h04, 32'h8f8f_0000);
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h04, 32'(c) << 16);
            rc("sel", 8'h04, 32'(c) << 16);
            chk("route", (c < 13 ? 32'h10 << c : c == 13 ? 8 : c == 14 ? 4 : 0)
                | 1, route());
        end
        wr(8'h04, 32'h0e80_0000);
        wr(8'h0c, 32'h3);
        wr(8'h00, 32'h8000);
        rc("ctrl", 8'h00, 32'h8000);
        wr(8'h00, 32'h8002);
        rc("ctrl", 8'h00, 32'h8002);
        chk("route", 32'h12, route());
        chk("sample_enable", 32'h1, 32'(o_sampling));
        wr(8'h00, 32'h8000);
        wirq;
        rc("stat", 8'h08, 32'h1);
        chk("irq", 32'h0, 32'(o_irq));
        rc("ctrl", 8'h00, 32'h8001);
        chk("route", 32'h5, route());
        wr(8'h00, 32'h8000);
        wr(8'h00, 32'h8001);
        rc("ctrl", 8'h00, 32'h8000);
        // auto restart without stop: results keep coming
        wr(8'h00, 32'h8024);
        rc("ctrl", 8'h00, 32'h8026);
        i_ext_trigger <= 1;
        repeat (2) @(posedge i_clk);
        i_ext_trigger <= 0;
        wirq;
        rc("stat", 8'h08, 32'h1);
        rc("ctrl", 8'h00, 32'h8027);
        i_ext_trigger <= 1;
        repeat (4) @(posedge i_clk);
        i_ext_trigger <= 0;
        rc("ctrl", 8'h00, 32'h8024);
        wirq;
        rc("stat", 8'h08, 32'h1);
        // stop on first interrupt, trigger held high
        i_ext_trigger <= 1;
        wr(8'h00, 32'h8034);
        wirq;
        rc("stat", 8'h08, 32'h3);
        rc("ctrl", 8'h00, 32'h8031);
        // counter-ended sampling, free-running
        wr(8'h00, 32'h80e4);
        wirq;
        rc("stat", 8'h08, 32'h1);
        end_of_test;
    end
endmodule // tb
